// File: rtl/mspsm_pkg.sv
// constants and types shared by the motion sensor power state manager
package mspsm_pkg;
    localparam int unsigned clk_hz = 40000000;
    localparam int unsigned cfg_power_index = 8'h05;
    localparam int unsigned cfg_auto_bit = 0;
    localparam int unsigned motion_x_index = 8'h21;
    localparam int unsigned motion_y_index = 8'h22;
    localparam int unsigned run_idle_ms = 50;
    localparam int unsigned short_period_ms = 10;
    localparam int unsigned short_hold_s = 8;
    localparam int unsigned long_period_ms = 100;
    localparam int unsigned sleep_after_min = 10;
    localparam int unsigned sleep_period_ms = 500;
    localparam int unsigned slow_ips = 4;
    localparam int unsigned fast_ips = 8;
    localparam int unsigned ms_cycles = clk_hz / 1000;
    localparam int unsigned run_idle_cycles = run_idle_ms * ms_cycles;
    localparam int unsigned short_period_cycles = short_period_ms * ms_cycles;
    localparam int unsigned short_hold_cycles = short_hold_s * 1000 * ms_cycles;
    localparam int unsigned long_period_cycles = long_period_ms * ms_cycles;
    localparam longint unsigned sleep_after_cycles = 64'(sleep_after_min) * 60 * 1000 * ms_cycles;
    localparam int unsigned sleep_period_cycles = sleep_period_ms * ms_cycles;
    localparam int unsigned timer_width = 36;
    localparam logic [1:0] rate_1k = 2'h0;
    localparam logic [1:0] rate_2k = 2'h1;
    localparam logic [1:0] rate_4k = 2'h2;
    typedef enum logic [2:0] {
        mspsm_off = 3'h0,
        mspsm_run = 3'h1,
        mspsm_short_doze = 3'h3,
        mspsm_long_doze = 3'h2,
        mspsm_sleep = 3'h6,
        mspsm_frame = 3'h7
    } mspsm_state_t;
endpackage

// File: rtl/mspsm_sync.sv
// two-flop synchroniser for the sleep control pin
`timescale 1ns/1ps
`default_nettype none
module mspsm_sync (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // pin and synchronised level
    input wire logic pin_in,
    output logic pin_sync
);
    logic meta;
    logic next_meta;
    logic next_sync;

    always_comb
    begin
        next_meta = pin_in;
        next_sync = meta;
    end

    // reset high: pin idles high, so no false wake follows reset
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            meta <= 1'b1;
            pin_sync <= 1'b1;
        end
        else
        begin
            meta <= next_meta;
            pin_sync <= next_sync;
        end
    end
endmodule
`default_nettype wire

// File: rtl/mspsm_top.sv
// power state manager: manual and automatic modes, motion flag, frame rate
// Contract
// R01 - manual mode after reset; controller steers state through sleep pin
// R02 - sleep pin low wakes analog and converter sections in fixed order; the code raises one power_up for both at once
// R03 - each manual wake runs exactly one frame
// R04 - controller holds sleep pin high in automatic mode after init
// R05 - config bit one selects automatic; flag follows motion
// R06 - config bit zero selects manual; flag is pin low and motion
// R07 - RUN rate 1K below 4 ips, 2K between 4 and 8, 4K above
// R08 - stay in RUN while motion continues
// R09 - automatic: 50 ms without motion in RUN goes to short doze
// R10 - short doze wakes every 10 ms for a frame; motion enters RUN
// R11 - after 8 s short doze, long doze wakes every 100 ms
// R12 - after 10 minutes without motion, fall into SLEEP
// R13 - SLEEP wakes once every 500 ms to check motion
// R14 - low-power states run one frame, reload wake timer, sleep again
// R15 - automatic mode raises flag on detected motion
// R16 - remain in RUN until host has read all pending motion data
// R17 - controller may stand by, resuming when the flag rises
// R18 - X and Y motion clear on read; host reads both together
// R19 - any motion restarts all inactivity timers
`timescale 1ns/1ps
`default_nettype none
module mspsm_top #(
    parameter logic [35:0] run_idle_cycles = 36'(mspsm_pkg::run_idle_cycles),
    parameter logic [35:0] short_period_cycles = 36'(mspsm_pkg::short_period_cycles),
    parameter logic [35:0] short_hold_cycles = 36'(mspsm_pkg::short_hold_cycles),
    parameter logic [35:0] long_period_cycles = 36'(mspsm_pkg::long_period_cycles),
    parameter logic [35:0] sleep_after_cycles = 36'(mspsm_pkg::sleep_after_cycles),
    parameter logic [35:0] sleep_period_cycles = 36'(mspsm_pkg::sleep_period_cycles)
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // pins
    input wire logic sleep_control_pin,
    output logic movement_flag,
    // configuration from the serial block
    input wire logic auto_mode,
    // motion engine
    input wire logic frame_done,
    input wire logic motion_seen,
    input wire logic [7:0] speed_ips,
    input wire logic motion_pending,
    // power and frame control
    output logic power_up,
    output logic frame_start,
    output logic [1:0] frame_rate,
    output logic [35:0] wake_period,
    output logic [2:0] power_state
);
    mspsm_pkg::mspsm_state_t state;
    mspsm_pkg::mspsm_state_t next_state;
    mspsm_pkg::mspsm_state_t resume;
    mspsm_pkg::mspsm_state_t next_resume;
    logic pin_sync;
    logic pin_prev;
    logic manual_busy;
    logic next_manual_busy;
    logic [35:0] idle_cnt;
    logic [35:0] next_idle_cnt;
    logic [35:0] doze_cnt;
    logic [35:0] next_doze_cnt;
    logic [35:0] wake_cnt;
    logic [35:0] next_wake_cnt;
    logic [35:0] next_wake_period;
    logic next_frame_start;
    logic next_flag;
    logic [1:0] next_rate;

    function automatic logic [35:0] bump(input logic [35:0] v);
        // saturate so long silences never wrap back to zero
        bump = (v == 36'hf_ffff_ffff) ? v : v + 36'h1;
    endfunction

    mspsm_sync u_sync (
        .clk(clk),
        .srst(srst),
        .pin_in(sleep_control_pin),
        .pin_sync(pin_sync)
    );

    always_comb
    begin
        next_state = state;
        next_resume = resume;
        next_manual_busy = manual_busy;
        next_idle_cnt = bump(idle_cnt);
        next_doze_cnt = bump(doze_cnt);
        next_wake_cnt = bump(wake_cnt);
        next_wake_period = wake_period;
        next_frame_start = 1'b0;
        next_rate = frame_rate;
        if (motion_seen)
        begin
            next_idle_cnt = 36'h0; // R19
            next_doze_cnt = 36'h0; // R19
        end
        if (!auto_mode)
        begin
            // manual: a falling pin edge powers up and runs one frame
            next_state = mspsm_pkg::mspsm_off; // R01
            if (pin_prev && !pin_sync && !manual_busy)
            begin
                next_manual_busy = 1'b1; // R02
                next_frame_start = 1'b1; // R03
            end
            else if (manual_busy && frame_done)
            begin
                next_manual_busy = 1'b0; // R03
            end
        end
        else
        begin
            next_manual_busy = 1'b0;
            case (state)
                mspsm_pkg::mspsm_off:
                begin
                    next_state = mspsm_pkg::mspsm_run; // R05
                    next_idle_cnt = 36'h0;
                end
                mspsm_pkg::mspsm_run:
                begin
                    if (motion_seen || motion_pending)
                    begin
                        next_idle_cnt = 36'h0; // R08 R16 R18
                    end
                    else if (idle_cnt >= run_idle_cycles - 36'h1)
                    begin
                        next_state = mspsm_pkg::mspsm_short_doze; // R09
                        next_doze_cnt = 36'h0;
                        next_wake_cnt = 36'h0;
                        next_wake_period = short_period_cycles; // R14
                    end
                end
                mspsm_pkg::mspsm_short_doze, mspsm_pkg::mspsm_long_doze,
                mspsm_pkg::mspsm_sleep:
                begin
                    if (state == mspsm_pkg::mspsm_short_doze && doze_cnt >= short_hold_cycles)
                    begin
                        next_state = mspsm_pkg::mspsm_long_doze; // R11
                        next_wake_period = long_period_cycles; // R11
                    end
                    else if (state != mspsm_pkg::mspsm_sleep && idle_cnt >= sleep_after_cycles)
                    begin
                        next_state = mspsm_pkg::mspsm_sleep; // R12
                        next_wake_period = sleep_period_cycles; // R13
                    end
                    else if (wake_cnt >= wake_period - 36'h1)
                    begin
                        next_resume = state;
                        next_state = mspsm_pkg::mspsm_frame; // R10 R13 R14
                        next_frame_start = 1'b1; // R14
                    end
                end
                mspsm_pkg::mspsm_frame:
                begin
                    if (frame_done)
                    begin
                        next_wake_cnt = 36'h0; // R14
                        if (motion_seen)
                        begin
                            next_state = mspsm_pkg::mspsm_run; // R10
                            next_idle_cnt = 36'h0;
                        end
                        else
                        begin
                            next_state = resume; // R14
                        end
                    end
                end
                default:
                begin
                    next_state = mspsm_pkg::mspsm_off;
                end
            endcase
        end
        // rate from speed in every state, doze frames included
        if (speed_ips > 8'(mspsm_pkg::fast_ips))
        begin
            next_rate = mspsm_pkg::rate_4k; // R07
        end
        else if (speed_ips >= 8'(mspsm_pkg::slow_ips))
        begin
            next_rate = mspsm_pkg::rate_2k; // R07
        end
        else
        begin
            next_rate = mspsm_pkg::rate_1k; // R07
        end
        if (auto_mode)
        begin
            next_flag = motion_seen || motion_pending; // R05 R15 R17
        end
        else
        begin
            next_flag = !pin_sync && motion_seen; // R06
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state <= mspsm_pkg::mspsm_off;
            resume <= mspsm_pkg::mspsm_short_doze;
            pin_prev <= 1'b1;
            manual_busy <= 1'b0;
            idle_cnt <= 36'h0;
            doze_cnt <= 36'h0;
            wake_cnt <= 36'h0;
            wake_period <= 36'h0;
            frame_start <= 1'b0;
            movement_flag <= 1'b0;
            frame_rate <= mspsm_pkg::rate_1k;
        end
        else
        begin
            state <= next_state;
            resume <= next_resume;
            pin_prev <= pin_sync;
            manual_busy <= next_manual_busy;
            idle_cnt <= next_idle_cnt;
            doze_cnt <= next_doze_cnt;
            wake_cnt <= next_wake_cnt;
            wake_period <= next_wake_period;
            frame_start <= next_frame_start;
            movement_flag <= next_flag;
            frame_rate <= next_rate;
        end
    end

    // sections are powered in RUN, during a wake frame or a manual wake
    assign power_up = manual_busy || state == mspsm_pkg::mspsm_run
        || state == mspsm_pkg::mspsm_frame; // R02
    assign power_state = state;
endmodule
`default_nettype wire

// File: verif/mspsm_asserts.sv
// port checker for the power state manager
`timescale 1ns/1ps
`default_nettype none
module mspsm_asserts #(
    parameter logic [35:0] run_idle_cycles = 36'h14
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // inputs of the block
    input wire logic sleep_control_pin,
    input wire logic auto_mode,
    input wire logic motion_seen,
    input wire logic motion_pending,
    input wire logic [7:0] speed_ips,
    // outputs of the block
    input wire logic movement_flag,
    input wire logic power_up,
    input wire logic frame_start,
    input wire logic [1:0] frame_rate,
    input wire logic [2:0] power_state
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);
    logic [35:0] idle;
    logic [35:0] next_idle;
    logic in_run;
    assign in_run = power_state == mspsm_pkg::mspsm_run;
    // cycles spent in run with nothing to report
    always_comb
        next_idle = (auto_mode && in_run && !motion_seen && !motion_pending) ? idle + 36'h1 : 36'h0;
    always_ff @(posedge clk)
        if (srst)
            idle <= 36'h0;
        else
            idle <= next_idle;

    a_reset_quiet: assert property (disable iff (1'b0) srst |=> power_state == 3'h0 && !movement_flag && !frame_start)
        else $error("outputs not quiet after reset");
    a_manual_asleep: assert property ((!auto_mode && sleep_control_pin) [*4] |-> !movement_flag)
        else $error("flag high while asleep in manual mode");
    a_manual_still: assert property ((!auto_mode && !motion_seen) [*3] |-> !movement_flag)
        else $error("flag high without motion in manual mode");
    a_auto_motion: assert property ((auto_mode && motion_seen) [*3] |-> movement_flag)
        else $error("flag low on motion in automatic mode");
    a_auto_quiet: assert property ((auto_mode && !motion_seen && !motion_pending) [*3] |-> !movement_flag)
        else $error("flag high without motion in automatic mode");
    a_rate_fast: assert property ((speed_ips > 8'h08) [*2] |-> frame_rate == mspsm_pkg::rate_4k)
        else $error("fast rate not chosen");
    a_rate_mid: assert property ((speed_ips >= 8'h04 && speed_ips <= 8'h08) [*2] |-> frame_rate == mspsm_pkg::rate_2k)
        else $error("middle rate not chosen");
    a_rate_slow: assert property ((speed_ips < 8'h04) [*2] |-> frame_rate == mspsm_pkg::rate_1k)
        else $error("slow rate not chosen");
    a_manual_wake: assert property (!auto_mode && !power_up && $fell(sleep_control_pin) |-> ##[1:5] frame_start)
        else $error("no frame after wake pulse");
    a_frame_powered: assert property (frame_start |-> power_up)
        else $error("frame started unpowered");
    a_run_held: assert property ((auto_mode && in_run && (motion_seen || motion_pending)) [*2] |=> in_run)
        else $error("left run with motion pending");
    a_run_timeout: assert property (idle > run_idle_cycles + 36'h4 |-> !in_run)
        else $error("run held past idle time");
endmodule
bind mspsm_top mspsm_asserts #(.run_idle_cycles(run_idle_cycles)) u_asserts (.clk, .srst,
    .sleep_control_pin, .auto_mode, .motion_seen, .motion_pending, .speed_ips, .movement_flag,
    .power_up, .frame_start, .frame_rate, .power_state);
`default_nettype wire

// File: verif/mspsm_host_model.sv
// controller and motion engine model facing the power state manager
`timescale 1ns/1ps
`default_nettype none
module mspsm_host_model #(
    parameter int frame_len = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // commands from the bench
    input wire logic wake_req,
    input wire logic moving,
    input wire logic hold_read,
    // device side
    input wire logic frame_start,
    input wire logic movement_flag,
    output logic sleep_control_pin = 1'b1,
    output logic frame_done = 1'b0,
    output logic motion_seen = 1'b0,
    output logic motion_pending = 1'b0
);
    int cnt = 0;
    always_ff @(posedge clk)
    begin
        // a one-cycle low pulse; otherwise the pin stays high, as automatic mode needs
        sleep_control_pin <= !wake_req;
        motion_seen <= moving;
        // x and y fetched together once the flag rises, which empties pending
        motion_pending <= moving || (motion_pending && (hold_read || !movement_flag));
        frame_done <= cnt == 1;
        if (srst)
            cnt <= 0;
        else if (frame_start)
            cnt <= frame_len;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
endmodule
`default_nettype wire

// File: verif/tb.sv
// self-checking bench for the power state manager
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic auto_mode;
    logic wake_req;
    logic moving;
    logic hold_read;
    logic [7:0] speed_ips;
    logic sleep_control_pin, frame_done, motion_seen, motion_pending;
    logic movement_flag, power_up, frame_start;
    logic [1:0] frame_rate;
    logic [2:0] power_state;
    logic [35:0] wake_period;
    int failures = 0;
    int compares = 0;
    int n;
    int m;
    always #12.5 clk = ~clk;
    mspsm_top #(.run_idle_cycles(36'h14), .short_period_cycles(36'h5), .short_hold_cycles(36'h64),
        .long_period_cycles(36'ha), .sleep_after_cycles(36'h12c), .sleep_period_cycles(36'hf)) dut (
        .clk, .srst, .sleep_control_pin, .movement_flag, .auto_mode, .frame_done, .motion_seen,
        .speed_ips, .motion_pending, .power_up, .frame_start, .frame_rate, .wake_period,
        .power_state);
    mspsm_host_model #(.frame_len(3)) host (.clk, .srst, .wake_req, .moving, .hold_read,
        .frame_start, .movement_flag, .sleep_control_pin, .frame_done, .motion_seen,
        .motion_pending);
    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1)
        begin
            failures++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic wait_state(input logic [2:0] s, input int lim);
        n = 0;
        // look only once the edge that may change the state has settled
        @(negedge clk);
        while (power_state !== s && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        check(power_state === s, "state not reached");
    endtask
    // the first gap may straddle the state change, so only the second is judged
    task automatic frame_gap(input logic [35:0] p);
        repeat (2)
        begin
            n = 0;
            @(negedge clk);
            while (frame_start !== 1'b1 && n < 99)
            begin
                @(negedge clk);
                n++;
            end
        end
        check(n + 1 >= p && n < p + 8 && wake_period === p, "wake period");
    endtask
    task automatic t_manual();
        @(negedge clk);
        check(power_state === 3'h0 && movement_flag === 1'b0, "reset state");
        @(posedge clk) moving <= 1'b1;
        wake_req <= 1'b1;
        @(posedge clk) wake_req <= 1'b0;
        n = 0;
        m = 0;
        repeat (30)
        begin
            @(negedge clk);
            if (frame_start === 1'b1)
                n++;
            if (movement_flag === 1'b1)
                m++;
        end
        check(n == 1, "manual frame count");
        check(m == 1, "flag while awake");
        check(power_up === 1'b0, "power held after frame");
        check(movement_flag === 1'b0, "flag while asleep");
        @(posedge clk) moving <= 1'b0;
        $display("manual test done");
    endtask
    task automatic t_rates();
        logic [7:0] sp [6] = '{8'h00, 8'h03, 8'h04, 8'h08, 8'h09, 8'hff};
        logic [1:0] rt [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
        foreach (sp[i])
        begin
            @(posedge clk) speed_ips <= sp[i];
            repeat (3) @(negedge clk);
            check(frame_rate === rt[i], "frame rate");
        end
        $display("rate test done");
    endtask
    task automatic t_auto();
        @(posedge clk) auto_mode <= 1'b1;
        moving <= 1'b1;
        wait_state(mspsm_pkg::mspsm_run, 10);
        repeat (60) @(negedge clk);
        check(power_state === mspsm_pkg::mspsm_run, "run on motion");
        check(movement_flag === 1'b1, "flag on motion");
        @(posedge clk) hold_read <= 1'b1;
        moving <= 1'b0;
        repeat (60) @(negedge clk);
        check(power_state === mspsm_pkg::mspsm_run, "run while unread");
        @(posedge clk) hold_read <= 1'b0;
        wait_state(mspsm_pkg::mspsm_short_doze, 40);
        check(n >= 18 && n <= 26, "run idle time");
        check(movement_flag === 1'b0, "flag without motion");
        frame_gap(36'h5);
        wait_state(mspsm_pkg::mspsm_long_doze, 200);
        check(n >= 60 && n <= 110, "short doze hold");
        frame_gap(36'ha);
        wait_state(mspsm_pkg::mspsm_sleep, 400);
        frame_gap(36'hf);
        @(posedge clk) moving <= 1'b1;
        wait_state(mspsm_pkg::mspsm_run, 40);
        @(posedge clk) moving <= 1'b0;
        wait_state(mspsm_pkg::mspsm_short_doze, 60);
        check(n <= 30, "timers restarted");
        @(posedge clk) auto_mode <= 1'b0;
        $display("automatic test done");
    endtask
    task automatic summarize();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        auto_mode <= 1'b0;
        wake_req <= 1'b0;
        moving <= 1'b0;
        hold_read <= 1'b0;
        speed_ips <= 8'h00;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        t_manual();
        t_rates();
        t_auto();
        summarize();
    end
    // the whole run needs about six hundred cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        summarize();
    end
endmodule
`default_nettype wire
